// File: rtl/sbt_pkg.sv
// sbt_pkg: constants and carriers for the sixteen-bit timer/counter.
// assumes one 100 MHz core clock; all users import the whole package.
package sbt_pkg;

  // core clock and instruction-cycle phase
  localparam int unsigned MCLK_HZ = 100_000_000;
  localparam logic [1:0] INSTR_PHASE_LAST = 2'h3;

  // auxiliary crystal oscillator ceiling, and how many core cycles one half
  // period of it spans at the least
  localparam int unsigned AUX_OSC_MAX_HZ = 200_000;
  localparam int unsigned AUX_OSC_HALF_CYC = MCLK_HZ / (2 * AUX_OSC_MAX_HZ);

  // control register layout
  localparam int unsigned CTL_RUN_BIT = 0;
  localparam int unsigned CTL_EXT_SRC_BIT = 1;
  localparam int unsigned CTL_SYNC_DIS_BIT = 2;
  localparam int unsigned CTL_OSC_EN_BIT = 3;
  localparam int unsigned CTL_PRESCALE_LSB = 4;
  localparam int unsigned CTL_PRESCALE_MSB = 5;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // flag position in the peripheral flag register
  localparam int unsigned OVF_FLAG_BIT = 0;

  // compare mode select value that asks for a special event trigger
  localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;

  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONES = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [2:0] PRE_ZERO = 3'h0;
  localparam logic [2:0] PRE_ONE = 3'h1;

  // prescale ratio select: 1:1, 1:2, 1:4, 1:8
  typedef enum logic [1:0] {
    SBT_PRE_1,
    SBT_PRE_2,
    SBT_PRE_4,
    SBT_PRE_8
  } sbt_prescale_t;

  typedef struct packed {
    logic [1:0] spare;
    sbt_prescale_t prescale;
    logic aux_oscillator_enable;
    logic async_input_sync_disable_n;
    logic ext_src;
    logic run;
  } sbt_ctl_t;

  typedef struct packed {
    logic [3:0] compare_mode_select;
    logic [15:0] compare_value_pair;
  } sbt_cmp_t;

endpackage

// File: rtl/sbt_pin_sync.sv
// sbt_pin_sync: three-stage input synchroniser with agreement filter.
// assumes the pin is asynchronous to mclk; output level and rising pulse
// come straight from flops.
`timescale 1ns/100ps
module sbt_pin_sync (
  input wire logic mclk,
  input wire logic reset,
  input wire logic pin,
  output logic level_q,
  output logic rise_q
);
  import sbt_pkg::*;

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      rise_q <= (s2_q == s3_q) && s2_q && !level_q;
      if (s2_q == s3_q) begin
        level_q <= s2_q;
      end
    end
  end

endmodule

// File: rtl/sbt_prescaler.sv
// sbt_prescaler: divides an input tick stream by 1, 2, 4 or 8.
// assumes tick_in is a one-cycle pulse on mclk; clear wins over counting.
`timescale 1ns/100ps
module sbt_prescaler (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clear,
  input wire sbt_pkg::sbt_prescale_t ratio,
  input wire logic tick_in,
  output logic tick_out
);
  import sbt_pkg::*;

  logic [2:0] cnt_q;
  logic [2:0] mask;

  always_comb begin
    case (ratio)
      SBT_PRE_1: mask = 3'h0;
      SBT_PRE_2: mask = 3'h1;
      SBT_PRE_4: mask = 3'h3;
      SBT_PRE_8: mask = 3'h7;
      default: mask = 3'h0;
    endcase
  end

  assign tick_out = tick_in && !clear && ((cnt_q & mask) == mask);

  always_ff @(posedge mclk) begin
    if (reset || clear) begin
      cnt_q <= PRE_ZERO;
    end else if (tick_in) begin
      cnt_q <= (cnt_q + PRE_ONE) & mask;
    end
  end

  property p_pre_clear;
    @(posedge mclk) disable iff (reset)
      clear |-> !tick_out ##1 (cnt_q == PRE_ZERO);
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

endmodule

// File: rtl/sbt_timer.sv
// sbt_timer: sixteen-bit timer/counter with prescaler, auxiliary oscillator
// and special-event reset from two compare units.
// assumes software drives plain control ports; no register bus.
//
// What this block does
// - sync disable set counts external edges unsynchronised
// - async mode counts in sleep, overflow wakes
// - async mode gives compare units no time base
// - count bytes always read as coherent value
// - oscillator enable bit runs the crystal amplifier
// - oscillator up to 200 kHz, runs in sleep
// - compare mode 1011 trigger resets the counter
// - trigger reset never sets the overflow flag
// - trigger reset only in timer/synchronised modes
// - count write beats a simultaneous trigger
// - compare value pair acts as period
// - count bytes untouched by any reset
// - control register clears only on power/brownout
// - count byte writes clear the prescaler
// - overflow sets flag, held until software or any reset clears
`timescale 1ns/100ps
module sbt_timer (
  input wire logic mclk,
  input wire logic reset,
  input wire logic power_on_reset,
  input wire logic brownout_reset,
  input wire logic ctl_write,
  input wire sbt_pkg::sbt_ctl_t ctl_wdata,
  input wire logic high_write,
  input wire logic low_write,
  input wire logic [7:0] count_wdata,
  input wire logic flag_clear,
  input wire logic sleep,
  input wire logic ext_clk_pin,
  input wire logic aux_osc_input_pin,
  input wire sbt_pkg::sbt_cmp_t compare_unit_a,
  input wire sbt_pkg::sbt_cmp_t compare_unit_b,
  output sbt_pkg::sbt_ctl_t timer_control_reg,
  output logic [7:0] count_high_byte,
  output logic [7:0] count_low_byte,
  output logic counter_overflow_flag,
  output logic wake_pulse,
  output logic match_a,
  output logic match_b,
  output logic aux_osc_output_pin,
  output logic aux_osc_output_en
);
  import sbt_pkg::*;

  logic por_any;
  logic any_reset;
  sbt_ctl_t ctl_q;
  logic [15:0] count_q;
  logic [1:0] phase_q;
  logic phase_tick;
  logic pend_q;
  logic ext_level;
  logic ext_rise;
  logic osc_level;
  logic osc_rise;
  logic async_mode;
  logic raw_tick;
  logic pre_tick;
  logic count_tick;
  logic cnt_write;
  logic evt_a;
  logic evt_b;
  logic evt_any;
  logic ovf_event;
  logic flag_q;

  assign por_any = power_on_reset || brownout_reset;
  assign any_reset = reset || por_any;

  sbt_pin_sync u_ext_sync (
    .mclk(mclk),
    .reset(any_reset),
    .pin(ext_clk_pin),
    .level_q(ext_level),
    .rise_q(ext_rise)
  );

  // oscillator input keeps being sampled in sleep so the crystal keeps going
  sbt_pin_sync u_osc_sync (
    .mclk(mclk),
    .reset(any_reset),
    .pin(aux_osc_input_pin),
    .level_q(osc_level),
    .rise_q(osc_rise)
  );

  // control register survives ordinary resets
  always_ff @(posedge mclk) begin
    if (por_any) begin
      ctl_q <= CTL_RESET;
    end else if (ctl_write) begin
      ctl_q <= ctl_wdata;
    end
  end

  // external edges with sync disabled are counted unaligned
  assign async_mode = ctl_q.ext_src && ctl_q.async_input_sync_disable_n;

  // instruction-cycle phase; stands still in sleep like the core clocks
  always_ff @(posedge mclk) begin
    if (any_reset) begin
      phase_q <= 2'h0;
    end else if (!sleep) begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign phase_tick = !sleep && (phase_q == INSTR_PHASE_LAST);

  // timer and synchronised modes need core clocks, so sleep freezes them
  always_comb begin
    raw_tick = 1'b0;
    if (ctl_q.run && (async_mode || !sleep)) begin
      if (ctl_q.ext_src) begin
        raw_tick = ctl_q.aux_oscillator_enable ? osc_rise : ext_rise;
      end else begin
        raw_tick = phase_tick;
      end
    end
  end

  assign cnt_write = high_write || low_write;

  sbt_prescaler u_pre (
    .mclk(mclk),
    .reset(any_reset),
    .clear(cnt_write),
    .ratio(ctl_q.prescale),
    .tick_in(raw_tick),
    .tick_out(pre_tick)
  );

  // synchronised ticks wait for the next phase boundary
  always_ff @(posedge mclk) begin
    if (any_reset || async_mode) begin
      pend_q <= 1'b0;
    end else if (phase_tick) begin
      pend_q <= 1'b0;
    end else if (pre_tick) begin
      pend_q <= 1'b1;
    end
  end

  always_comb begin
    if (async_mode) begin
      count_tick = pre_tick;
    end else begin
      count_tick = phase_tick && (pend_q || pre_tick);
    end
  end

  // special event only where the count is a valid compare time base
  assign evt_a = !async_mode && (compare_unit_a.compare_mode_select == MODE_SPECIAL_EVENT)
    && (count_q == compare_unit_a.compare_value_pair);
  assign evt_b = !async_mode && (compare_unit_b.compare_mode_select == MODE_SPECIAL_EVENT)
    && (count_q == compare_unit_b.compare_value_pair);
  assign evt_any = evt_a || evt_b;

  assign ovf_event = count_tick && !cnt_write && !evt_any
    && (count_q == COUNT_ONES);

  // no reset here: the count keeps its value through every reset;
  // a write that lands on an increment simply wins, software must stop first
  always_ff @(posedge mclk) begin
    if (cnt_write) begin
      if (high_write) begin
        count_q[15:8] <= count_wdata;
      end
      if (low_write) begin
        count_q[7:0] <= count_wdata;
      end
    end else if (evt_any) begin
      count_q <= COUNT_ZERO;
    end else if (count_tick) begin
      count_q <= count_q + COUNT_ONE;
    end
  end

  // set beats clear; the trigger path never reaches here
  always_ff @(posedge mclk) begin
    if (any_reset) begin
      flag_q <= 1'b0;
    end else if (ovf_event) begin
      flag_q <= 1'b1;
    end else if (flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (any_reset) begin
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= ovf_event && sleep;
    end
  end

  // both bytes from one snapshot, so a read never sees a torn value
  always_ff @(posedge mclk) begin
    count_high_byte <= count_q[15:8];
    count_low_byte <= count_q[7:0];
  end

  always_ff @(posedge mclk) begin
    if (any_reset) begin
      match_a <= 1'b0;
      match_b <= 1'b0;
    end else begin
      match_a <= !async_mode && (count_q == compare_unit_a.compare_value_pair);
      match_b <= !async_mode && (count_q == compare_unit_b.compare_value_pair);
    end
  end

  // inverting amplifier; 200 kHz keeps each half period far above one mclk
  always_ff @(posedge mclk) begin
    if (any_reset) begin
      aux_osc_output_pin <= 1'b0;
      aux_osc_output_en <= 1'b0;
    end else begin
      aux_osc_output_pin <= ctl_q.aux_oscillator_enable && !osc_level;
      aux_osc_output_en <= ctl_q.aux_oscillator_enable;
    end
  end

  assign timer_control_reg = ctl_q;
  assign counter_overflow_flag = flag_q;

  property p_async_count;
    @(posedge mclk) disable iff (any_reset)
      (async_mode && pre_tick && !cnt_write && count_q != COUNT_ONES)
        |=> count_q == $past(count_q) + COUNT_ONE;
  endproperty
  a_async_count: assert property (p_async_count) else $error("async tick not counted");

  property p_sleep_wake;
    @(posedge mclk) disable iff (any_reset)
      (sleep && async_mode && ovf_event) |=> wake_pulse && flag_q;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("no wake on overflow");

  property p_async_no_match;
    @(posedge mclk) disable iff (any_reset)
      async_mode |=> !match_a && !match_b;
  endproperty
  a_async_no_match: assert property (p_async_no_match) else $error("match in async");

  property p_coherent_read;
    @(posedge mclk) disable iff (any_reset)
      ##1 1'b1 |-> {count_high_byte, count_low_byte} == $past(count_q);
  endproperty
  a_coherent_read: assert property (p_coherent_read) else $error("torn count read");

  property p_osc_enable;
    @(posedge mclk) disable iff (any_reset)
      !ctl_q.aux_oscillator_enable |=> !aux_osc_output_en && !aux_osc_output_pin;
  endproperty
  a_osc_enable: assert property (p_osc_enable) else $error("amplifier on when off");

  property p_event_reset;
    @(posedge mclk) disable iff (any_reset)
      (evt_any && !cnt_write) |=> (count_q == COUNT_ZERO) && (flag_q == $past(flag_q)
        || $past(flag_clear));
  endproperty
  a_event_reset: assert property (p_event_reset)
    else $error("trigger reset wrong");

  property p_async_no_event;
    @(posedge mclk) disable iff (any_reset)
      async_mode |-> !evt_a && !evt_b;
  endproperty
  a_async_no_event: assert property (p_async_no_event) else $error("trigger in async");

  property p_write_wins;
    @(posedge mclk) disable iff (any_reset)
      (evt_any && high_write && low_write) |=> count_q == {2{$past(count_wdata)}};
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("trigger beat write");

  property p_count_keeps;
    @(posedge mclk)
      (any_reset && !cnt_write && !evt_any && !count_tick) |=> $stable(count_q);
  endproperty
  a_count_keeps: assert property (p_count_keeps) else $error("count hit by reset");

  property p_ctl_reset;
    @(posedge mclk)
      (reset && !por_any) |=> ctl_q == $past(ctl_q) || $past(ctl_write);
  endproperty
  a_ctl_reset: assert property (p_ctl_reset) else $error("control lost on reset");

  property p_ctl_por;
    @(posedge mclk) por_any |=> ctl_q == CTL_RESET;
  endproperty
  a_ctl_por: assert property (p_ctl_por) else $error("control not cleared");

  property p_flag_hold;
    @(posedge mclk) disable iff (any_reset)
      (flag_q && !flag_clear) |=> flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

  property p_wrap;
    @(posedge mclk) disable iff (any_reset)
      ovf_event |=> (count_q == COUNT_ZERO) && flag_q;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap not seen");

endmodule

// File: verif/sbt_clk_src.sv
// sbt_clk_src: far-side model, external count clock and watch crystal.
// assumes bursts are asked for on mclk; the crystal swings only while the
// timer drives its amplifier pin.
`timescale 1ns/100ps
module sbt_clk_src #(
  parameter int HALF = 6,
  parameter int START = 300,
  parameter int OSC_HALF = 250
) (
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] n_pulses,
  input wire logic amp_en,
  output logic ext_clk_pin,
  output logic aux_osc_input_pin,
  output logic osc_quiet
);
  int ph_q = 0;
  int left_q = 0;
  int on_q = 0;
  initial ext_clk_pin = 1'b0;
  initial aux_osc_input_pin = 1'b0;
  // an even number of toggles, so the pin rests low between bursts
  always @(posedge mclk) begin
    ph_q <= (ph_q == HALF - 1) ? 0 : ph_q + 1;
    if (go) begin
      left_q <= 2 * n_pulses;
    end else if (ph_q == HALF - 1 && left_q > 0) begin
      ext_clk_pin <= ~ext_clk_pin;
      left_q <= left_q - 1;
    end
  end
  // 250 cycles a half period is 200 kHz at 100 MHz
  // no swing before the start-up time has run out
  always @(posedge mclk) begin
    on_q <= amp_en ? on_q + 1 : 0;
    if (!amp_en) begin
      aux_osc_input_pin <= 1'b0;
    end else if (on_q >= START && (on_q - START) % OSC_HALF == 0) begin
      aux_osc_input_pin <= ~aux_osc_input_pin;
    end
  end
  // far from either edge, so the synchronised copy has settled
  assign osc_quiet = amp_en && on_q > START && (on_q - START) % OSC_HALF > 10
    && (on_q - START) % OSC_HALF < OSC_HALF - 4;
endmodule

// File: verif/tb_sbt_timer.sv
// tb_sbt_timer: self-checking bench for the sixteen-bit timer/counter.
// assumes sbt_pkg and sbt_clk_src are compiled before it.
`timescale 1ns/100ps
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, s); end end
module tb_sbt_timer;
  import sbt_pkg::*;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m; int at;} sbt_note_t;
  logic mclk = 1'b0, reset = 1'b1, power_on_reset = 1'b1, brownout_reset = 1'b0;
  // count has no reset, so both bytes are loaded while reset is held
  logic ctl_write = 1'b0, high_write = 1'b1, low_write = 1'b1, flag_clear = 1'b0;
  logic sleep = 1'b0, go = 1'b0;
  logic [7:0] count_wdata = 8'h00, n_pulses = 8'h00, v;
  sbt_ctl_t ctl_wdata = '0, timer_control_reg;
  sbt_cmp_t compare_unit_a = '0, compare_unit_b = '0;
  logic [7:0] count_high_byte, count_low_byte;
  logic counter_overflow_flag, wake_pulse, match_a, match_b, osc_quiet;
  logic aux_osc_output_pin, aux_osc_output_en, ext_clk_pin, aux_osc_input_pin;
  int n_errors = 0, checks = 0, seed = 32'h6959, ncyc = 0, wakes = 0, p, k;
  sbt_note_t notes[$];
  wire [31:0] obs = {timer_control_reg, count_high_byte, count_low_byte,
    counter_overflow_flag, match_a, match_b, aux_osc_output_pin, aux_osc_output_en, 3'h0};

  always #5 mclk = ~mclk;

  sbt_timer sbt_timer_inst (.mclk, .reset, .power_on_reset, .brownout_reset, .ctl_write,
    .ctl_wdata, .high_write, .low_write, .count_wdata, .flag_clear, .sleep, .ext_clk_pin,
    .aux_osc_input_pin, .compare_unit_a, .compare_unit_b, .timer_control_reg,
    .count_high_byte, .count_low_byte, .counter_overflow_flag, .wake_pulse, .match_a,
    .match_b, .aux_osc_output_pin, .aux_osc_output_en);
  sbt_clk_src sbt_clk_src_inst (.mclk, .go, .n_pulses, .amp_en(aux_osc_output_en),
    .ext_clk_pin, .aux_osc_input_pin, .osc_quiet);

  // notes fall due at a negedge, well clear of the edge that drives inputs
  always @(negedge mclk) begin
    while (notes.size() > 0 && notes[0].at == ncyc) begin
      `CHK(notes[0].nm, notes[0].e & notes[0].m, obs & notes[0].m)
      void'(notes.pop_front());
    end
    if (wake_pulse === 1'b1) begin
      `CHK("wake", 1'b1, wakes > 0)
      wakes--;
    end
    ncyc++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic ex(input string nm, input logic [31:0] e, input logic [31:0] m, input int d);
    notes.push_back('{nm, e, m, ncyc + d});
  endtask
  task automatic wr_ctl(input sbt_ctl_t d);
    ctl_wdata <= d;
    ctl_write <= 1'b1;
    tick(1);
    ctl_write <= 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic h, input logic l, input logic [7:0] d);
    count_wdata <= d;
    {high_write, low_write} <= {h, l};
    tick(1);
    {high_write, low_write} <= 2'h0;
    tick(1);
  endtask
  task automatic wait_for(input string nm, input logic [31:0] e, input logic [31:0] m);
    int i;
    i = 0;
    do begin
      @(negedge mclk);
      i++;
    end while (i < 4000 && (obs & m) !== (e & m));
    if ((obs & m) !== (e & m)) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, e & m, obs & m);
      test_done();
    end
    @(posedge mclk);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    tick(6);
    reset <= 1'b0;
    power_on_reset <= 1'b0;
    {high_write, low_write} <= 2'h0;
    tick(1);
    ex("por ctl", 32'h0, 32'hFF00_0000, 0);
    wr(1, 0, 8'hA5);
    wr(0, 1, 8'h3C);
    for (int r = 0; r < 3; r++) begin
      wr_ctl(8'h32);
      {reset, power_on_reset, brownout_reset} <= 3'h4 >> r;
      tick(1);
      {reset, power_on_reset, brownout_reset} <= 3'h0;
      tick(1);
      ex("reset", {(r == 0 ? 8'h32 : 8'h00), 24'hA53C00}, 32'hFFFF_FF80, 0);
    end
    $display("resets done");
    wr_ctl(8'h03);
    for (int u = 0; u < 2; u++) begin
      v = 8'($random(seed));
      compare_unit_a <= {(u == 0 ? MODE_SPECIAL_EVENT : 4'h0), v, v};
      compare_unit_b <= {(u == 1 ? MODE_SPECIAL_EVENT : 4'h0), v, v};
      wr(1, 1, v);
      ex("trigger", 32'h0, 32'h00FF_FF80, 1);
      count_wdata <= v;
      {high_write, low_write} <= 2'h3;
      tick(1);
      count_wdata <= ~v;
      tick(1);
      {high_write, low_write} <= 2'h0;
      ex("write wins", {8'h00, ~v, ~v, 8'h00}, 32'h00FF_FF80, 3);
      tick(4);
    end
    $display("trigger done");
    compare_unit_a <= '0;
    compare_unit_b <= '0;
    for (int r = 0; r < 4; r++) begin
      p = 4 << r;
      k = 1 + $unsigned($random(seed)) % 3;
      wr_ctl({2'h0, 2'(r), 4'h0});
      flag_clear <= 1'b1;
      wr(1, 0, 8'hFF);
      flag_clear <= 1'b0;
      wr(0, 1, 8'hFF);
      wr_ctl({2'h0, 2'(r), 4'h1});
      wait_for("overflow", 32'h80, 32'h80);
      ex("wrap", 32'h80, 32'h00FF_FF80, 0);
      ex("count", {8'h00, 16'(k), 8'h80}, 32'h00FF_FF80, p * k);
      tick(p * k + p / 2);
      count_wdata <= 8'h40;
      low_write <= 1'b1;
      tick(1);
      low_write <= 1'b0;
      ex("pre clear", 32'h4080, 32'h00FF_FF80, p / 2);
      tick(p);
    end
    $display("prescale done");
    for (int a = 0; a < 2; a++) begin
      wr_ctl(8'h02);
      flag_clear <= 1'b1;
      wr(1, 1, 8'h00);
      flag_clear <= 1'b0;
      k = 1 + $unsigned($random(seed)) % 20;
      compare_unit_a <= {4'h8, 16'(k)};
      compare_unit_b <= {4'h0, 16'(k)};
      wr_ctl(a ? 8'h07 : 8'h03);
      sleep <= a[0];
      n_pulses <= 8'(k);
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(12 * k + 30);
      ex("ext", {8'h00, 16'(k), 1'b0, a == 0, a == 0, 5'h0},
        32'h00FF_FFE0, 0);
      tick(1);
    end
    wr_ctl(8'h02);
    wr(1, 1, 8'hFF);
    wr_ctl(8'h07);
    wakes++;
    n_pulses <= 8'h01;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    wait_for("sleep overflow", 32'h80, 32'h80);
    sleep <= 1'b0;
    flag_clear <= 1'b1;
    tick(1);
    flag_clear <= 1'b0;
    ex("flag clear", 32'h0, 32'h80, 1);
    $display("external done");
    wr_ctl(8'h08);
    ex("osc on", 32'h08, 32'h08, 1);
    tick(350);
    for (int h = 0; h < 2; h++) begin
      for (int i = 0; i < 300 && osc_quiet !== 1'b1; i++) tick(1);
      `CHK("osc quiet", 1'b1, osc_quiet)
      ex("osc pin", {27'h0, ~aux_osc_input_pin, 4'h8}, 32'h18, 0);
      tick(250);
    end
    wr_ctl(8'h00);
    ex("osc off", 32'h0, 32'h18, 1);
    tick(5);
    $display("oscillator done");
    `CHK("left over", 0, notes.size() + wakes)
    test_done();
  end

  initial begin
    #200_000;
    n_errors++;
    $display("FAIL run exp end got hang");
    test_done();
  end
endmodule
